// ### adc_ctrl_pkg.sv
// Shared constants and types for the converter control front end
`default_nettype none
package adc_ctrl_pkg;
   //==========================================================
   // Control register layout
   localparam logic [7:0] CTRL_RST   = 8'h00;
   localparam logic [7:0] RESULT_RST = 8'h80;
   localparam int         OE_BIT     = 6;
   localparam int         CFG_HI     = 5;
   localparam int         CFG_LO     = 4;
   localparam int         AINC_BIT   = 2;
   localparam int         CH_HI      = 1;
   localparam int         CH_LO      = 0;
   //==========================================================
   // Input configurations
   localparam logic [1:0] CFG_SE4    = 2'h0;
   localparam logic [1:0] CFG_DIF3   = 2'h1;
   localparam logic [1:0] CFG_MIX    = 2'h2;
   localparam logic [1:0] CFG_DIF2   = 2'h3;
   //==========================================================
   // Link framing and timing
   localparam logic [3:0] BIT_ACK    = 4'h8;
   localparam logic [3:0] BIT_FIRST  = 4'h1;
   localparam logic [3:0] BIT_ZERO   = 4'h0;
   localparam int         CONV_NS    = 160;
   localparam int         CLK_NS     = 20;
   localparam int         CONV_CYC   = CONV_NS / CLK_NS;

   typedef enum logic [2:0] {
      ST_ADDR, ST_CTRL, ST_DATA, ST_READ, ST_IDLE
   } link_state_e;
endpackage : adc_ctrl_pkg
`default_nettype wire

// ### link_if.sv
// Carrier between the serial link engine and the converter core
`timescale 1ns/1ns
`default_nettype none
interface link_if;
   logic       link_hold;
   logic       sda_in;
   logic       sda_oe;
   logic [2:0] addr_pins;
   logic [7:0] result;
   logic [7:0] hold_byte;
   logic       hold_is_dac;
   logic       wr_tgl;
   logic       conv_tgl;
   modport eng  (input link_hold, sda_in, addr_pins, result,
                 output sda_oe, hold_byte, hold_is_dac, wr_tgl, conv_tgl);
   modport core (output link_hold, sda_in, addr_pins, result,
                 input sda_oe, hold_byte, hold_is_dac, wr_tgl, conv_tgl);
endinterface : link_if
`default_nettype wire

// ### serial_link_engine.sv
// Serial bus slave engine running on the bus clock
`timescale 1ns/1ns
`default_nettype none
module serial_link_engine
   import adc_ctrl_pkg::*;
#(
   parameter logic [3:0] FIXED_ADDR = 4'h4  // Arbitrary fixed address part
)(
   input  wire logic scl_clk_i,
   input  wire logic rst_i,
   link_if.eng       lk
);
   logic [2:0]  pin_ff1, pin_ff2;
   logic [3:0]  cnt, next_cnt;
   logic [7:0]  rx, next_rx, tx, next_tx;
   link_state_e st, next_st;
   logic        sda_pos, next_sda_pos;
   logic        restart, next_restart;
   logic        oe, next_oe;
   logic        next_conv, next_wr;
   logic        match;

   //==========================================================
   // Address pins, held across frames
   always_ff @(posedge scl_clk_i or posedge rst_i) begin
      if (rst_i) begin
         pin_ff1 <= 3'h0;
         pin_ff2 <= 3'h0;
      end else begin
         pin_ff1 <= lk.addr_pins;
         pin_ff2 <= pin_ff1;
      end
   end

   assign match = (rx[7:1] == {FIXED_ADDR, pin_ff2});

   //==========================================================
   // Bit sampling on the rising bus clock
   always_comb begin
      next_rx      = {rx[6:0], lk.sda_in};
      next_sda_pos = lk.sda_in;
      next_cnt     = cnt + BIT_FIRST;
      next_st      = st;
      if (restart) begin
         next_cnt = BIT_FIRST;
         next_st  = ST_ADDR;
      end else if (cnt == BIT_ACK) begin
         next_cnt = BIT_ZERO;
         next_rx  = rx;
         unique case (st)
            ST_ADDR: begin
               if (!match) next_st = ST_IDLE;
               else if (rx[0]) next_st = ST_READ;
               else next_st = ST_CTRL;
            end
            ST_CTRL: next_st = ST_DATA;
            ST_READ: if (lk.sda_in) next_st = ST_IDLE;
            ST_DATA, ST_IDLE: next_st = st;
         endcase
      end
   end

   always_ff @(posedge scl_clk_i or posedge lk.link_hold) begin
      if (lk.link_hold) begin
         cnt     <= BIT_ZERO;
         rx      <= 8'h00;
         st      <= ST_ADDR;
         sda_pos <= 1'b0;
      end else begin
         cnt     <= next_cnt;
         rx      <= next_rx;
         st      <= next_st;
         sda_pos <= next_sda_pos;
      end
   end

   //==========================================================
   // Written byte handed to the core with a toggle
   assign next_wr = (!restart && cnt == BIT_ACK &&
                     (st == ST_CTRL || st == ST_DATA)) ? ~lk.wr_tgl : lk.wr_tgl;

   always_ff @(posedge scl_clk_i or posedge rst_i) begin
      if (rst_i) begin
         lk.hold_byte   <= 8'h00;
         lk.hold_is_dac <= 1'b0;
         lk.wr_tgl      <= 1'b0;
      end else if (next_wr != lk.wr_tgl) begin
         lk.hold_byte   <= rx;
         lk.hold_is_dac <= (st == ST_DATA);
         lk.wr_tgl      <= next_wr;
      end
   end

   //==========================================================
   // Data line drive on the falling bus clock
   always_comb begin
      next_restart = sda_pos & ~lk.sda_in;
      next_oe      = 1'b0;
      next_tx      = {tx[6:0], 1'b0};
      next_conv    = lk.conv_tgl;
      if (!next_restart) begin
         if (cnt == BIT_ACK) begin
            next_oe = (st == ST_ADDR && match) || st == ST_CTRL || st == ST_DATA;
         end else if (st == ST_READ) begin
            if (cnt == BIT_ZERO) begin
               next_tx   = lk.result;
               next_conv = ~lk.conv_tgl;
            end
            next_oe = ~next_tx[7];
         end
      end
   end

   always_ff @(negedge scl_clk_i or posedge lk.link_hold) begin
      if (lk.link_hold) begin
         restart <= 1'b0;
         oe      <= 1'b0;
         tx      <= 8'h00;
      end else begin
         restart <= next_restart;
         oe      <= next_oe;
         tx      <= next_tx;
      end
   end

   always_ff @(negedge scl_clk_i or posedge rst_i) begin
      if (rst_i) lk.conv_tgl <= 1'b0;
      else lk.conv_tgl <= next_conv;
   end

   assign lk.sda_oe = oe;

   //==========================================================
   // Checks on the bus clock
   default clocking cb @(posedge scl_clk_i); endclocking
   default disable iff (lk.link_hold);

   property p_ack_match;
      (cnt == BIT_ACK && st == ST_ADDR && match && !restart) |-> oe;
   endproperty
   a_ack_match: assert property (p_ack_match)
      else $error("matching address not acknowledged");

   property p_quiet_other;
      (cnt == BIT_ACK && st == ST_ADDR && !match) |-> !oe;
   endproperty
   a_quiet_other: assert property (p_quiet_other)
      else $error("data line driven for foreign address");
endmodule : serial_link_engine
`default_nettype wire

// ### adc_dac_i2c_control_byte.sv
// Converter control front end: bus slave, control byte and conversion core
// Functional notes
// - Respond only after matching address byte
// - Match fixed part plus three pin bits
// - Eight devices share one bus
// - Last address bit selects transfer direction
// - Second written byte loads control register
// - Upper nibble: output enable, input configuration
// - Lower nibble selects converted input channel
// - Auto-increment advances channel after conversion
// - Missing channel maps to highest channel
// - Auto-increment wraps past highest to zero
// - Power-on reset clears control register
// - Converter and oscillator off after reset
// - Analog output high impedance after reset
// - Conversions paced by bus transfers only
// - Third written byte loads converter data
// - Read address acknowledge starts new conversion
// - Read returns previous result, first 80h
// - Differential results in two's complement
`timescale 1ns/1ns
`default_nettype none
module adc_dac_i2c_control_byte
   import adc_ctrl_pkg::*;
#(
   parameter logic [3:0] FIXED_ADDR = 4'h4,  // Arbitrary fixed address part
   parameter int         CONV_LEN   = CONV_CYC
)(
   input  wire logic       ref_clk_i,
   input  wire logic       rst_i,
   input  wire logic       scl_clk_i,
   input  wire logic       sda_i,
   output logic            sda_o,
   output logic            sda_oe_o,
   input  wire logic       addr_sel_pin_lsb_i,
   input  wire logic       addr_sel_pin_mid_i,
   input  wire logic       addr_sel_pin_msb_i,
   input  wire logic [7:0] analog_in_ch_zero_i,
   input  wire logic [7:0] analog_in_ch_one_i,
   input  wire logic [7:0] analog_in_ch_two_i,
   input  wire logic [7:0] analog_in_ch_three_i,
   output logic [7:0]      dac_code_o,
   output logic            analog_out_pin_en_o,
   output logic            osc_en_o,
   output logic [1:0]      ch_sel_o
);
   link_if lk();

   logic [3:0][7:0] ain_raw, ain_ff1, ain_ff2;
   logic [2:0] scl_s, sda_s, wr_s, cv_s;
   logic       hold, next_hold, start_seen, stop_seen;
   logic       wr_ev, cv_ev, ctrl_wr, dac_wr;
   logic [7:0] conversion_control, next_ctrl;
   logic [7:0] dac, next_dac, result, next_result, samp, next_samp;
   logic [1:0] cur_ch, next_ch;
   logic [7:0] busy, next_busy;
   logic       conv_done;

   //==========================================================
   // Link engine
   assign lk.sda_in    = sda_i;
   assign lk.addr_pins = {addr_sel_pin_msb_i, addr_sel_pin_mid_i, addr_sel_pin_lsb_i};
   assign lk.link_hold = hold;
   assign lk.result    = result;
   assign sda_oe_o     = lk.sda_oe;

   serial_link_engine #(
      .FIXED_ADDR (FIXED_ADDR)
   ) u_link (
      .scl_clk_i (scl_clk_i),
      .rst_i     (rst_i),
      .lk        (lk)
   );

   //==========================================================
   // Start and stop watch; holds the link engine idle between frames
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         scl_s <= 3'h7;
         sda_s <= 3'h7;
      end else begin
         scl_s <= {scl_s[1:0], scl_clk_i};
         sda_s <= {sda_s[1:0], sda_i};
      end
   end

   assign start_seen = scl_s[1] & scl_s[2] & sda_s[2] & ~sda_s[1];
   assign stop_seen  = scl_s[1] & scl_s[2] & ~sda_s[2] & sda_s[1];

   always_comb begin
      next_hold = hold;
      if (stop_seen) next_hold = 1'b1;
      else if (start_seen) next_hold = 1'b0;
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) hold <= 1'b1;
      else hold <= next_hold;
   end

   //==========================================================
   // Event crossings from the link clock
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         wr_s <= 3'h0;
         cv_s <= 3'h0;
      end else begin
         wr_s <= {wr_s[1:0], lk.wr_tgl};
         cv_s <= {cv_s[1:0], lk.conv_tgl};
      end
   end

   assign wr_ev   = wr_s[2] ^ wr_s[1];
   assign cv_ev   = cv_s[2] ^ cv_s[1];
   assign ctrl_wr = wr_ev & ~lk.hold_is_dac;
   assign dac_wr  = wr_ev & lk.hold_is_dac;

   //==========================================================
   // Analog input codes
   assign ain_raw = {analog_in_ch_three_i, analog_in_ch_two_i,
                     analog_in_ch_one_i, analog_in_ch_zero_i};

   for (genvar g = 0; g < 4; g++) begin : g_ain
      always_ff @(posedge ref_clk_i or posedge rst_i) begin
         if (rst_i) begin
            ain_ff1[g] <= 8'h00;
            ain_ff2[g] <= 8'h00;
         end else begin
            ain_ff1[g] <= ain_raw[g];
            ain_ff2[g] <= ain_ff1[g];
         end
      end
   end

   //==========================================================
   // Channel helpers
   function automatic logic [1:0] max_ch(input logic [1:0] cfg);
      unique case (cfg)
         CFG_SE4:           max_ch = 2'h3;
         CFG_DIF3, CFG_MIX: max_ch = 2'h2;
         CFG_DIF2:          max_ch = 2'h1;
      endcase
   endfunction : max_ch

   function automatic logic [1:0] clamp_ch(input logic [1:0] cfg,
                                           input logic [1:0] ch);
      clamp_ch = (ch > max_ch(cfg)) ? max_ch(cfg) : ch;
   endfunction : clamp_ch

   function automatic logic [7:0] diff(input logic [7:0] a, input logic [7:0] b);
      logic signed [8:0] d;
      d = $signed({1'b0, a}) - $signed({1'b0, b});
      if (d > 9'sd127) diff = 8'h7F;
      else if (d < -9'sd128) diff = 8'h80;
      else diff = d[7:0];
   endfunction : diff

   function automatic logic [7:0] pick(input logic [1:0] cfg, input logic [1:0] ch,
                                       input logic [3:0][7:0] a);
      unique case (cfg)
         CFG_SE4:  pick = a[ch];
         CFG_DIF3: pick = diff(a[ch], a[3]);
         CFG_MIX:  pick = (ch == 2'h2) ? diff(a[2], a[3]) : a[ch];
         CFG_DIF2: pick = ch[0] ? diff(a[2], a[3]) : diff(a[0], a[1]);
      endcase
   endfunction : pick

   //==========================================================
   // Control, data and conversion state
   assign conv_done = (busy == 8'h01);

   always_comb begin
      next_ctrl   = conversion_control;
      next_dac    = dac;
      next_ch     = cur_ch;
      next_samp   = samp;
      next_result = result;
      next_busy   = (busy != 8'h00) ? busy - 8'h01 : 8'h00;
      if (cv_ev) begin
         next_samp = pick(conversion_control[CFG_HI:CFG_LO], cur_ch, ain_ff2);
         next_busy = CONV_LEN[7:0];
      end
      if (conv_done) begin
         next_result = samp;
         if (conversion_control[AINC_BIT]) begin
            next_ch = (cur_ch >= max_ch(conversion_control[CFG_HI:CFG_LO])) ?
                      2'h0 : cur_ch + 2'h1;
         end
      end
      if (ctrl_wr) begin
         next_ctrl = lk.hold_byte;
         next_ch   = clamp_ch(lk.hold_byte[CFG_HI:CFG_LO],
                              lk.hold_byte[CH_HI:CH_LO]);
      end
      if (dac_wr) next_dac = lk.hold_byte;
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         conversion_control <= CTRL_RST;
         dac                <= 8'h00;
         cur_ch             <= 2'h0;
         samp               <= 8'h00;
         result             <= RESULT_RST;
         busy               <= 8'h00;
      end else begin
         conversion_control <= next_ctrl;
         dac                <= next_dac;
         cur_ch             <= next_ch;
         samp               <= next_samp;
         result             <= next_result;
         busy               <= next_busy;
      end
   end

   //==========================================================
   // Output registers
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         sda_o               <= 1'b0;
         dac_code_o          <= 8'h00;
         analog_out_pin_en_o <= 1'b0;
         osc_en_o            <= 1'b0;
         ch_sel_o            <= 2'h0;
      end else begin
         sda_o               <= 1'b0;
         dac_code_o          <= dac;
         analog_out_pin_en_o <= conversion_control[OE_BIT];
         osc_en_o            <= conversion_control[OE_BIT] | (busy != 8'h00);
         ch_sel_o            <= cur_ch;
      end
   end

   //==========================================================
   // Checks on the system clock
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);

   property p_reset_values;
      $fell(rst_i) |-> conversion_control == 8'h00 && result == 8'h80;
   endproperty
   a_reset_values: assert property (p_reset_values)
      else $error("control or result not at reset value");

   property p_ctrl_load;
      ctrl_wr |=> conversion_control == $past(lk.hold_byte);
   endproperty
   a_ctrl_load: assert property (p_ctrl_load)
      else $error("control byte not stored");

   property p_ctrl_hold;
      !ctrl_wr |=> $stable(conversion_control);
   endproperty
   a_ctrl_hold: assert property (p_ctrl_hold)
      else $error("control register changed without write");

   property p_dac_out;
      dac_wr |=> ##1 dac_code_o == $past(lk.hold_byte, 2);
   endproperty
   a_dac_out: assert property (p_dac_out)
      else $error("converter data not driven out");

   property p_out_off;
      !conversion_control[OE_BIT] |=> !analog_out_pin_en_o;
   endproperty
   a_out_off: assert property (p_out_off)
      else $error("analog output enabled while flag clear");

   property p_osc_off;
      (!conversion_control[OE_BIT] && busy == 8'h00) |=> !osc_en_o;
   endproperty
   a_osc_off: assert property (p_osc_off)
      else $error("oscillator running while idle");

   property p_ch_range;
      cur_ch <= max_ch(conversion_control[CFG_HI:CFG_LO]) || $past(ctrl_wr) == 1'b0;
   endproperty
   a_ch_range: assert property (p_ch_range)
      else $error("channel beyond configuration");

   property p_wrap;
      (conv_done && !ctrl_wr && conversion_control[AINC_BIT] &&
       cur_ch == max_ch(conversion_control[CFG_HI:CFG_LO])) |=> cur_ch == 2'h0;
   endproperty
   a_wrap: assert property (p_wrap)
      else $error("auto-increment did not wrap");

   property p_conv_done;
      cv_ev |-> ##[1:300] conv_done;
   endproperty
   a_conv_done: assert property (p_conv_done)
      else $error("conversion did not finish");

   property p_idle_quiet;
      hold |-> !lk.sda_oe;
   endproperty
   a_idle_quiet: assert property (p_idle_quiet)
      else $error("data line driven between frames");
endmodule : adc_dac_i2c_control_byte
`default_nettype wire

// ### bus_master_model.sv
// Behavioural two-wire bus master that makes the link clock
`timescale 1ns/1ns
`default_nettype none
module bus_master_model (
   output logic      scl_o,
   output logic      sda_pull_o,
   input  wire logic sda_i
);
   localparam int LO_NS = 62;
   localparam int HI_NS = 63;

   initial begin
      scl_o      = 1'b1;
      sda_pull_o = 1'b0;
   end

   //==========================================================
   // One clock pulse, data changed only in the middle of the low phase
   task automatic bit_cell(input logic b, output logic seen);
      #(LO_NS / 2);
      sda_pull_o = ~b;
      #(LO_NS - LO_NS / 2);
      scl_o = 1'b1;
      #(HI_NS / 2);
      seen = sda_i;
      #(HI_NS - HI_NS / 2);
      scl_o = 1'b0;
   endtask : bit_cell

   task automatic start();
      if (scl_o == 1'b0) begin
         #(LO_NS / 2);
         sda_pull_o = 1'b0;
         #(LO_NS - LO_NS / 2);
         scl_o = 1'b1;
      end
      #(HI_NS);
      sda_pull_o = 1'b1;
      #(HI_NS);
      scl_o = 1'b0;
   endtask : start

   task automatic stop();
      #(LO_NS / 2);
      sda_pull_o = 1'b1;
      #(LO_NS - LO_NS / 2);
      scl_o = 1'b1;
      #(HI_NS);
      sda_pull_o = 1'b0;
      #(HI_NS * 2);
   endtask : stop

   task automatic send_byte(input logic [7:0] b, output logic ack);
      logic seen;
      for (int i = 7; i >= 0; i--) begin
         bit_cell(b[i], seen);
      end
      bit_cell(1'b1, seen);
      ack = ~seen;
   endtask : send_byte

   task automatic recv_byte(input logic give_ack, output logic [7:0] b);
      logic seen;
      for (int i = 7; i >= 0; i--) begin
         bit_cell(1'b1, seen);
         b[i] = seen;
      end
      bit_cell(~give_ack, seen);
   endtask : recv_byte

   // Address byte goes first after every start, direction in its last bit
   task automatic address(input logic [6:0] a, input logic rd, output logic ack);
      start();
      send_byte({a, rd}, ack);
   endtask : address
endmodule : bus_master_model
`default_nettype wire

// ### testbench.sv
// Self-checking bench for the converter control front end
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import adc_ctrl_pkg::*;
   localparam logic [3:0] FIXED = 4'h4;
   logic       ref_clk;
   logic       rst;
   logic       scl;
   logic       sda_pull;
   logic       sda_line;
   logic       sda_o;
   logic       sda_oe;
   logic [2:0] pins;
   logic [7:0] ain [4];
   logic [7:0] dac_code;
   logic       out_en;
   logic       osc_en;
   logic [1:0] ch_sel;
   int         fail_count;
   int         cmp_count;

   // Open-drain wire with pull-up
   assign sda_line = ~(sda_pull | sda_oe);

   adc_dac_i2c_control_byte #(.FIXED_ADDR(FIXED), .CONV_LEN(8)) adc_dac_i2c_control_byte_inst (
      .ref_clk_i(ref_clk), .rst_i(rst), .scl_clk_i(scl), .sda_i(sda_line),
      .sda_o(sda_o), .sda_oe_o(sda_oe), .addr_sel_pin_lsb_i(pins[0]),
      .addr_sel_pin_mid_i(pins[1]), .addr_sel_pin_msb_i(pins[2]),
      .analog_in_ch_zero_i(ain[0]), .analog_in_ch_one_i(ain[1]),
      .analog_in_ch_two_i(ain[2]), .analog_in_ch_three_i(ain[3]),
      .dac_code_o(dac_code), .analog_out_pin_en_o(out_en), .osc_en_o(osc_en),
      .ch_sel_o(ch_sel));

   bus_master_model bus_master_model_inst (.scl_o(scl), .sda_pull_o(sda_pull), .sda_i(sda_line));

   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end

   //==========================================================
   // Shared tasks
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic results();
      if (fail_count == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : results

   task automatic wait_ref(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : wait_ref

   // Address then one control byte; a refused address must leave control alone
   task automatic probe(input logic [6:0] a, input logic exp_ack);
      logic ack;
      bus_master_model_inst.address(a, 1'b0, ack);
      check(ack, exp_ack);
      bus_master_model_inst.send_byte(exp_ack ? 8'h00 : 8'h44, ack);
      check(ack, exp_ack);
      bus_master_model_inst.stop();
      wait_ref(10);
      check(out_en, 1'b0);
   endtask : probe

   task automatic write_ctrl(input logic [7:0] ctrl, input logic [7:0] data,
                             input logic with_data);
      logic ack;
      bus_master_model_inst.address({FIXED, pins}, 1'b0, ack);
      check(ack, 1'b1);
      bus_master_model_inst.send_byte(ctrl, ack);
      check(ack, 1'b1);
      if (with_data) begin
         bus_master_model_inst.send_byte(data, ack);
         check(ack, 1'b1);
      end
      bus_master_model_inst.stop();
      wait_ref(10);
   endtask : write_ctrl

   // Reads n bytes, the last one refused; exp holds them first byte highest
   task automatic read_bytes(input int n, input logic [63:0] exp);
      logic       ack;
      logic [7:0] b;
      bus_master_model_inst.address({FIXED, pins}, 1'b1, ack);
      check(ack, 1'b1);
      for (int k = 0; k < n; k++) begin
         bus_master_model_inst.recv_byte(k < n - 1, b);
         check(b, exp[63 - 8 * k -: 8]);
      end
      bus_master_model_inst.stop();
      wait_ref(20);
   endtask : read_bytes

   // Control write, then a repeated start straight into a two-byte read
   task automatic restart_read(input logic [7:0] ctrl, input logic [15:0] exp);
      logic       ack;
      logic [7:0] b;
      bus_master_model_inst.address({FIXED, pins}, 1'b0, ack);
      check(ack, 1'b1);
      bus_master_model_inst.send_byte(ctrl, ack);
      check(ack, 1'b1);
      bus_master_model_inst.address({FIXED, pins}, 1'b1, ack);
      check(ack, 1'b1);
      bus_master_model_inst.recv_byte(1'b1, b);
      check(b, exp[15:8]);
      bus_master_model_inst.recv_byte(1'b0, b);
      check(b, exp[7:0]);
      bus_master_model_inst.stop();
      wait_ref(20);
   endtask : restart_read

   initial begin
      #400000;
      fail_count++;
      results();
   end

   //==========================================================
   // Main sequence
   initial begin
      rst = 1'b0;
      pins = 3'h0;
      ain[0] = 8'h11;
      ain[1] = 8'h22;
      ain[2] = 8'h33;
      ain[3] = 8'h44;
      fail_count = 0;
      cmp_count = 0;
      // Reset rises just after time zero so every reset process sees the edge
      #1;
      rst = 1'b1;
      wait_ref(3);
      rst <= 1'b0;
      wait_ref(5);
      check(dac_code, 8'h00);
      check(osc_en, 1'b0);
      check(out_en, 1'b0);
      check(ch_sel, 2'h0);
      check(sda_oe, 1'b0);
      for (int p = 0; p < 8; p++) begin
         pins <= 3'(p);
         wait_ref(2);
         probe({FIXED, 3'(p)}, 1'b1);
         probe({FIXED, 3'(p) ^ 3'h5}, 1'b0);
      end
      probe({FIXED ^ 4'h1, pins}, 1'b0);
      read_bytes(1, 64'h80 << 56);
      write_ctrl(8'h44, 8'hA5, 1'b1);
      check(out_en, 1'b1);
      check(osc_en, 1'b1);
      check(dac_code, 8'hA5);
      check(ch_sel, 2'h0);
      read_bytes(6, 64'h1111_2233_4411_0000);
      check(ch_sel, 2'h2);
      write_ctrl(8'h33, 8'h00, 1'b0);
      check(ch_sel, 2'h1);
      check(out_en, 1'b0);
      read_bytes(2, 64'h22EF << 48);
      check(ch_sel, 2'h1);
      check(dac_code, 8'hA5);
      check(osc_en, 1'b0);
      check(sda_o, 1'b0);
      rst <= 1'b1;
      wait_ref(3);
      rst <= 1'b0;
      wait_ref(5);
      check(dac_code, 8'h00);
      check(out_en, 1'b0);
      check(ch_sel, 2'h0);
      read_bytes(1, 64'h80 << 56);
      restart_read(8'h01, 16'h1122);
      check(ch_sel, 2'h1);
      results();
   end
endmodule : testbench
`default_nettype wire
